// [pbwo_consts.vh]
// Purpose: Constants for the six-channel buffered PWM wave output stage
// Assumes: Byte-addressed register port, byte address = index * 4
// Notes: Field positions are bit indices inside 32-bit register words
//
// Summary of operation
// - Counter and comparators use only shadow copies
// - Default: shadows load at period end
// - Period end depends on counting mode
// - Immediate-load bit updates shadow on write
// - Immediate load overrides center and period loading
// - Larger new period: count up to it
// - Smaller new period: wrap through 0xffff
// - Center load copies compare at peak
// - Center mode still loads period at end
// - Events: zero, period, own and partner compare up/down
// - Per-event action: none, low, high, toggle
// - Up counting coincident events priority order
// - Down counting coincident events priority order
// - Up-down counting five-level priority order
// - Output path: mask, polarity, enable
// - Override enable replaces generated waveform
// - Override level drives masked channels
// - Per-channel polarity, default active high
// - Up-down counting with direction flag
`ifndef PBWO_CONSTS_VH
`define PBWO_CONSTS_VH

// Register byte addresses
`define PBWO_ADDR_CHAN_CTL 8'h00
`define PBWO_ADDR_CNT_CTL 8'h04
`define PBWO_ADDR_PERIOD 8'h08
`define PBWO_ADDR_CNT_STAT 8'h0c
`define PBWO_ADDR_WAVE_A 8'h10
`define PBWO_ADDR_WAVE_B 8'h14
`define PBWO_ADDR_OVR_EN 8'h18
`define PBWO_ADDR_OVR_LVL 8'h1c
`define PBWO_ADDR_NEG_POL 8'h20
`define PBWO_ADDR_OUT_EN 8'h24
`define PBWO_ADDR_PSHADOW 8'h28
`define PBWO_ADDR_CMP_BASE 8'h40
`define PBWO_ADDR_CSHADOW_BASE 8'h60

// Field positions
`define PBWO_CENTER_LO 0
`define PBWO_IMM_LO 16
`define PBWO_MODE_LO 0
`define PBWO_RUN_BIT 8
`define PBWO_DIR_BIT 16
`define PBWO_PRD_ACT_LO 16
`define PBWO_COMPARE_MATCH_DOWN_ACT_LO 16

// Counting modes
`define PBWO_MODE_UP 2'h0
`define PBWO_MODE_DOWN 2'h1
`define PBWO_MODE_UPDOWN 2'h2

// Wave actions
`define PBWO_ACT_NONE 2'h0
`define PBWO_ACT_LOW 2'h1
`define PBWO_ACT_HIGH 2'h2
`define PBWO_ACT_TOGGLE 2'h3

// Reset values
`define PBWO_RST_16 16'h0000
`define PBWO_RST_6 6'h00
`define PBWO_RST_32 32'h00000000

`endif

// [pbwo_top.v]
// Purpose: Six-channel shared-counter PWM with double buffering and output control
// Assumes: cnt_tick_i is the prescaled count enable, synchronous to clk_i
// Notes: Register reads return data one cycle after the read strobe
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/100ps
`include "pbwo_consts.vh"

module pbwo_top (
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   input wire cnt_tick_i,
   input wire [7:0] addr_i,
   input wire [31:0] wr_data_i,
   input wire wr_i,
   input wire rd_i,
   output reg [31:0] rd_data_o,
   output reg [5:0] pwm_o,
   output reg [5:0] pwm_oe_o
);

   // Software-visible state
   reg [5:0] center_load_enable_r;
   reg [5:0] immediate_load_enable_r;
   reg [1:0] mode_r;
   reg run_r;
   reg [15:0] period_r;
   reg [31:0] wave_action_control_a_r;
   reg [31:0] wave_action_control_b_r;
   reg [5:0] override_enable_r;
   reg [5:0] override_level_r;
   reg [5:0] negative_polarity_r;
   reg [5:0] out_en_r;
   reg [15:0] compare_value_r [0:5];

   // Hardware state
   reg [15:0] period_shadow_r;
   reg [15:0] compare_shadow_r [0:5];
   reg [15:0] counter_value_r;
   reg count_direction_flag_r;
   reg [5:0] wave_r;

   // Next values
   reg [15:0] period_shadow_nxt;
   reg [15:0] counter_value_nxt;
   reg count_direction_flag_nxt;
   reg [31:0] rd_data_nxt;
   wire [5:0] wave_nxt;
   wire [5:0] pwm_nxt;

   integer i;

   wire mode_up = (mode_r != `PBWO_MODE_DOWN) && (mode_r != `PBWO_MODE_UPDOWN);
   wire mode_dn = (mode_r == `PBWO_MODE_DOWN);
   wire mode_ud = (mode_r == `PBWO_MODE_UPDOWN);
   wire step = run_r & cnt_tick_i;
   wire at_zero = (counter_value_r == 16'h0000);
   wire at_prd = (counter_value_r == period_shadow_r);
   wire imm_any = |immediate_load_enable_r;
   wire wr_period = wr_i && (addr_i == `PBWO_ADDR_PERIOD);

   // Effective direction; the turning points belong to the leg they start
   wire dir_eff = mode_ud ? (at_zero ? 1'b1 : (at_prd ? 1'b0 : count_direction_flag_r)) : mode_up;

   // Period completion per counting mode
   wire prd_done = step & (mode_ud ? (at_zero & ~count_direction_flag_r) :
                           (mode_dn ? at_zero : at_prd));
   // Peak of an up-down period
   wire center_pt = step & mode_ud & at_prd & count_direction_flag_r;

   // Compare write decode, one strobe per channel
   wire [5:0] wr_cmp;
   genvar g;
   generate
      for (g = 0; g < 6; g = g + 1) begin : g_wdec
         assign wr_cmp[g] = wr_i && (addr_i == (`PBWO_ADDR_CMP_BASE + 8'h04 * g));
      end
   endgenerate

   // Returns the action of the highest-priority event present, slot 0 highest
   function [1:0] pbwo_pick;
      input [4:0] ev;
      input [9:0] act;
      integer k;
      begin
         pbwo_pick = `PBWO_ACT_NONE;
         for (k = 4; k >= 0; k = k - 1) begin
            if (ev[k]) begin
               pbwo_pick = act[2*k +: 2];
            end
         end
      end
   endfunction

   // Software register writes
   always @(posedge clk_i) begin
      if (rst_i) begin
         center_load_enable_r <= `PBWO_RST_6;
         immediate_load_enable_r <= `PBWO_RST_6;
         mode_r <= `PBWO_MODE_UP;
         run_r <= 1'b0;
         period_r <= `PBWO_RST_16;
         wave_action_control_a_r <= `PBWO_RST_32;
         wave_action_control_b_r <= `PBWO_RST_32;
         override_enable_r <= `PBWO_RST_6;
         override_level_r <= `PBWO_RST_6;
         negative_polarity_r <= `PBWO_RST_6;
         out_en_r <= `PBWO_RST_6;
         for (i = 0; i < 6; i = i + 1) begin
            compare_value_r[i] <= `PBWO_RST_16;
         end
      end else if (ce_i && wr_i) begin
         case (addr_i)
            `PBWO_ADDR_CHAN_CTL: begin
               center_load_enable_r <= wr_data_i[`PBWO_CENTER_LO +: 6];
               immediate_load_enable_r <= wr_data_i[`PBWO_IMM_LO +: 6];
            end
            `PBWO_ADDR_CNT_CTL: begin
               mode_r <= wr_data_i[`PBWO_MODE_LO +: 2];
               run_r <= wr_data_i[`PBWO_RUN_BIT];
            end
            `PBWO_ADDR_PERIOD: period_r <= wr_data_i[15:0];
            `PBWO_ADDR_WAVE_A: wave_action_control_a_r <= wr_data_i;
            `PBWO_ADDR_WAVE_B: wave_action_control_b_r <= wr_data_i;
            `PBWO_ADDR_OVR_EN: override_enable_r <= wr_data_i[5:0];
            `PBWO_ADDR_OVR_LVL: override_level_r <= wr_data_i[5:0];
            `PBWO_ADDR_NEG_POL: negative_polarity_r <= wr_data_i[5:0];
            `PBWO_ADDR_OUT_EN: out_en_r <= wr_data_i[5:0];
            default: begin
               for (i = 0; i < 6; i = i + 1) begin
                  if (wr_cmp[i]) begin
                     compare_value_r[i] <= wr_data_i[15:0];
                  end
               end
            end
         endcase
      end
   end

   // Period shadow: immediate write wins, else load at period end
   always @* begin
      period_shadow_nxt = period_shadow_r;
      if (wr_period && imm_any) begin
         period_shadow_nxt = wr_data_i[15:0];
      end else if (prd_done) begin
         period_shadow_nxt = period_r;
      end
   end

   // Shared counter; the up count wraps through 0xffff when it is above a new period
   always @* begin
      counter_value_nxt = counter_value_r;
      count_direction_flag_nxt = count_direction_flag_r;
      if (!run_r) begin
         counter_value_nxt = 16'h0000;
         count_direction_flag_nxt = ~mode_dn;
      end else if (step) begin
         if (mode_dn) begin
            count_direction_flag_nxt = 1'b0;
            if (at_zero) begin
               counter_value_nxt = period_shadow_nxt;
            end else begin
               counter_value_nxt = counter_value_r - 16'h0001;
            end
         end else if (mode_ud) begin
            if (count_direction_flag_r) begin
               if (at_prd) begin
                  count_direction_flag_nxt = 1'b0;
                  counter_value_nxt = at_zero ? 16'h0000 : counter_value_r - 16'h0001;
               end else begin
                  counter_value_nxt = counter_value_r + 16'h0001;
               end
            end else begin
               if (at_zero) begin
                  count_direction_flag_nxt = 1'b1;
                  counter_value_nxt = (period_shadow_nxt == 16'h0000) ? 16'h0000 : 16'h0001;
               end else begin
                  counter_value_nxt = counter_value_r - 16'h0001;
               end
            end
         end else begin
            count_direction_flag_nxt = 1'b1;
            if (at_prd) begin
               counter_value_nxt = 16'h0000;
            end else begin
               counter_value_nxt = counter_value_r + 16'h0001;
            end
         end
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         period_shadow_r <= `PBWO_RST_16;
         counter_value_r <= `PBWO_RST_16;
         count_direction_flag_r <= 1'b1;
      end else if (ce_i) begin
         period_shadow_r <= period_shadow_nxt;
         counter_value_r <= counter_value_nxt;
         count_direction_flag_r <= count_direction_flag_nxt;
      end
   end

   // Compare shadows
   always @(posedge clk_i) begin
      if (rst_i) begin
         for (i = 0; i < 6; i = i + 1) begin
            compare_shadow_r[i] <= `PBWO_RST_16;
         end
      end else if (ce_i) begin
         for (i = 0; i < 6; i = i + 1) begin
            if (immediate_load_enable_r[i]) begin
               if (wr_cmp[i]) begin
                  compare_shadow_r[i] <= wr_data_i[15:0];
               end
            end else if (mode_ud && center_load_enable_r[i]) begin
               if (center_pt) begin
                  compare_shadow_r[i] <= compare_value_r[i];
               end
            end else if (prd_done) begin
               compare_shadow_r[i] <= compare_value_r[i];
            end
         end
      end
   end

   // Per-channel event resolution; partner channel is the other of the pair
   generate
      for (g = 0; g < 6; g = g + 1) begin : g_wave
         wire hit_n = (counter_value_r == compare_shadow_r[g]);
         wire hit_m = (counter_value_r == compare_shadow_r[g ^ 1]);
         wire ez = step & at_zero;
         wire ep = step & at_prd;
         wire eun = step & hit_n & dir_eff;
         wire eum = step & hit_m & dir_eff;
         wire edn = step & hit_n & ~dir_eff;
         wire edm = step & hit_m & ~dir_eff;
         wire [1:0] az = wave_action_control_a_r[2*g +: 2];
         wire [1:0] ap = wave_action_control_a_r[`PBWO_PRD_ACT_LO + 2*g +: 2];
         wire [1:0] aun = wave_action_control_b_r[2*g +: 2];
         wire [1:0] aum = wave_action_control_b_r[2*(g ^ 1) +: 2];
         wire [1:0] adn = wave_action_control_b_r[`PBWO_COMPARE_MATCH_DOWN_ACT_LO + 2*g +: 2];
         wire [1:0] adm = wave_action_control_b_r[`PBWO_COMPARE_MATCH_DOWN_ACT_LO + 2*(g ^ 1) +: 2];
         reg [1:0] act;
         always @* begin
            if (mode_ud && dir_eff) begin
               act = pbwo_pick({edn, edm, ez, eun, eum}, {adn, adm, az, aun, aum});
            end else if (mode_ud) begin
               act = pbwo_pick({eun, eum, ep, edn, edm}, {aun, aum, ap, adn, adm});
            end else if (mode_dn) begin
               act = pbwo_pick({1'b0, ep, edn, edm, ez}, {2'b00, ap, adn, adm, az});
            end else begin
               act = pbwo_pick({1'b0, ez, eun, eum, ep}, {2'b00, az, aun, aum, ap});
            end
         end
         assign wave_nxt[g] = !run_r ? 1'b0 :
                              (act == `PBWO_ACT_LOW) ? 1'b0 :
                              (act == `PBWO_ACT_HIGH) ? 1'b1 :
                              (act == `PBWO_ACT_TOGGLE) ? ~wave_r[g] : wave_r[g];
         // Mask first, then polarity
         assign pwm_nxt[g] = (override_enable_r[g] ? override_level_r[g] : wave_r[g])
                             ^ negative_polarity_r[g];
      end
   endgenerate

   // Waveform and pin stage; flops keep the pins glitch-free
   always @(posedge clk_i) begin
      if (rst_i) begin
         wave_r <= `PBWO_RST_6;
         pwm_o <= `PBWO_RST_6;
         pwm_oe_o <= `PBWO_RST_6;
      end else if (ce_i) begin
         wave_r <= wave_nxt;
         pwm_o <= pwm_nxt;
         pwm_oe_o <= out_en_r;
      end
   end

   // Read mux; unmapped addresses read zero
   always @* begin
      rd_data_nxt = `PBWO_RST_32;
      case (addr_i)
         `PBWO_ADDR_CHAN_CTL: begin
            rd_data_nxt[`PBWO_CENTER_LO +: 6] = center_load_enable_r;
            rd_data_nxt[`PBWO_IMM_LO +: 6] = immediate_load_enable_r;
         end
         `PBWO_ADDR_CNT_CTL: begin
            rd_data_nxt[`PBWO_MODE_LO +: 2] = mode_r;
            rd_data_nxt[`PBWO_RUN_BIT] = run_r;
         end
         `PBWO_ADDR_PERIOD: rd_data_nxt[15:0] = period_r;
         `PBWO_ADDR_CNT_STAT: begin
            rd_data_nxt[15:0] = counter_value_r;
            rd_data_nxt[`PBWO_DIR_BIT] = count_direction_flag_r;
         end
         `PBWO_ADDR_WAVE_A: rd_data_nxt = wave_action_control_a_r;
         `PBWO_ADDR_WAVE_B: rd_data_nxt = wave_action_control_b_r;
         `PBWO_ADDR_OVR_EN: rd_data_nxt[5:0] = override_enable_r;
         `PBWO_ADDR_OVR_LVL: rd_data_nxt[5:0] = override_level_r;
         `PBWO_ADDR_NEG_POL: rd_data_nxt[5:0] = negative_polarity_r;
         `PBWO_ADDR_OUT_EN: rd_data_nxt[5:0] = out_en_r;
         `PBWO_ADDR_PSHADOW: rd_data_nxt[15:0] = period_shadow_r;
         default: begin
            for (i = 0; i < 6; i = i + 1) begin
               if (addr_i == (`PBWO_ADDR_CMP_BASE + 8'h04 * i)) begin
                  rd_data_nxt[15:0] = compare_value_r[i];
               end
               if (addr_i == (`PBWO_ADDR_CSHADOW_BASE + 8'h04 * i)) begin
                  rd_data_nxt[15:0] = compare_shadow_r[i];
               end
            end
         end
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always @(posedge clk_i) begin
      if (rst_i) begin
         rd_data_o <= `PBWO_RST_32;
      end else if (ce_i) begin
         rd_data_o <= rd_i ? rd_data_nxt : `PBWO_RST_32;
      end
   end

endmodule // pbwo_top

// [pbwo_chk.sv]
// Purpose: Port checker for the PWM wave output stage
// Assumes: Registers change only through the write strobe
// Notes: quiet_r waits out the register-to-pin lag
`timescale 1ns/100ps
module pbwo_chk (
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   input wire [7:0] addr_i,
   input wire [31:0] wr_data_i,
   input wire wr_i,
   input wire rd_i,
   input wire [31:0] rd_data_o,
   input wire [5:0] pwm_o,
   input wire [5:0] pwm_oe_o
);
   reg [5:0] en_r, lvl_r, pol_r, oe_r, imm_r;
   reg [8:0] ctl_r;
   reg [1:0] quiet_r;
   always @(posedge clk_i) begin
      if (rst_i) begin
         {en_r, lvl_r, pol_r, oe_r, imm_r, ctl_r, quiet_r} <= 41'h0;
      end else if (ce_i) begin
         quiet_r <= wr_i ? 2'h0 : quiet_r + {1'b0, quiet_r != 2'h3};
         if (wr_i && addr_i == 8'h00) imm_r <= wr_data_i[21:16];
         if (wr_i && addr_i == 8'h04) ctl_r <= wr_data_i[8:0];
         if (wr_i && addr_i == 8'h18) en_r <= wr_data_i[5:0];
         if (wr_i && addr_i == 8'h1c) lvl_r <= wr_data_i[5:0];
         if (wr_i && addr_i == 8'h20) pol_r <= wr_data_i[5:0];
         if (wr_i && addr_i == 8'h24) oe_r <= wr_data_i[5:0];
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_mask;
      quiet_r == 2'h3 |-> (pwm_o & en_r) == ((lvl_r ^ pol_r) & en_r);
   endproperty
   a_mask: assert property (p_mask) else $error("masked pin wrong");
   property p_idle;
      quiet_r == 2'h3 && !ctl_r[8] |-> (pwm_o & ~en_r) == (pol_r & ~en_r);
   endproperty
   a_idle: assert property (p_idle) else $error("idle pin wrong");
   property p_oe;
      quiet_r == 2'h3 |-> pwm_oe_o == oe_r;
   endproperty
   a_oe: assert property (p_oe) else $error("enable wrong");
   property p_rd_en;
      ce_i && rd_i && addr_i == 8'h18 |=> rd_data_o == {26'h0, en_r};
   endproperty
   a_rd_en: assert property (p_rd_en) else $error("mask enable read wrong");
   property p_rd_pol;
      ce_i && rd_i && addr_i == 8'h20 |=> rd_data_o == {26'h0, pol_r};
   endproperty
   a_rd_pol: assert property (p_rd_pol) else $error("polarity read wrong");
   property p_stop;
      ce_i && rd_i && addr_i == 8'h0c && !ctl_r[8] && quiet_r == 2'h3
         |=> rd_data_o == {15'h0, ctl_r[1:0] != 2'h1, 16'h0};
   endproperty
   a_stop: assert property (p_stop) else $error("stopped count wrong");
   property p_pimm;
      ce_i && wr_i && addr_i == 8'h08 && imm_r != 6'h0 ##1 ce_i && rd_i && addr_i == 8'h28
         |=> rd_data_o[15:0] == $past(wr_data_i[15:0], 2);
   endproperty
   a_pimm: assert property (p_pimm) else $error("period not loaded");
   property p_cimm;
      ce_i && wr_i && addr_i == 8'h40 && imm_r[0] ##1 ce_i && rd_i && addr_i == 8'h60
         |=> rd_data_o[15:0] == $past(wr_data_i[15:0], 2);
   endproperty
   a_cimm: assert property (p_cimm) else $error("compare not loaded");
endmodule // pbwo_chk
bind pbwo_top pbwo_chk chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i),
   .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
   .pwm_o(pwm_o), .pwm_oe_o(pwm_oe_o));

// [pbwo_pins.sv]
// Purpose: Pin-side model of the six PWM outputs
// Assumes: Pins carry no pull resistor
// Notes: A released pin shows a level that changes every cycle
`timescale 1ns/100ps
module pbwo_pins (
   input wire clk_i,
   input wire [5:0] pwm_i,
   input wire [5:0] oe_i,
   output wire [5:0] pin_o
);
   reg [5:0] last_r = 6'h00;
   // Floating pins must never look like a held level
   assign pin_o = (oe_i & pwm_i) | (~oe_i & ~last_r);
   always @(posedge clk_i) begin
      last_r <= pin_o;
   end
endmodule // pbwo_pins

// [test_pwm_buffer_wave_output.sv]
// Purpose: Self-checking bench for the PWM wave output stage
// Assumes: Counter steps on every clock while running
// Notes: Duty is counted over one whole period, so phase does not matter
`timescale 1ns/100ps
`include "pbwo_consts.vh"
module test_pwm_buffer_wave_output;
   localparam [95:0] CMPV = {16'h18, 16'h10, 16'h20, 16'h20, 16'h00, 16'h04};
   // Ch4 toggles at zero and at 0x10, so it is high for counts 0x10..0x20
   localparam [47:0] DUTY = {8'h10, 8'h11, 8'h01, 8'h21, 8'h00, 8'h00};
   reg clk_i = 1'b0;
   reg rst_i = 1'b1;
   reg ce_i = 1'b1;
   reg cnt_tick_i = 1'b0;
   reg [7:0] addr_i = 8'h00;
   reg [31:0] wr_data_i = 32'h0;
   reg wr_i = 1'b0;
   reg rd_i = 1'b0;
   wire [31:0] rd_data_o;
   wire [5:0] pwm_o, pwm_oe_o, pin;
   integer failures = 0;
   integer checks = 0;
   integer cyc = 0;
   integer i, k;
   integer hi [0:5];
   always #12.5 clk_i = ~clk_i;
   pbwo_top uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cnt_tick_i(cnt_tick_i),
      .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
      .rd_data_o(rd_data_o), .pwm_o(pwm_o), .pwm_oe_o(pwm_oe_o));
   pbwo_pins pins (.clk_i(clk_i), .pwm_i(pwm_o), .oe_i(pwm_oe_o), .pin_o(pin));
   task close_out;
      begin
         $display("checks %0d failures %0d", checks, failures);
         if (failures == 0 && checks > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   always @(posedge clk_i) begin
      cyc = cyc + 1;
      if (cyc == 3000) begin
         failures = failures + 1;
         close_out;
      end
   end
   task cmp(input [31:0] exp, input [31:0] got, input [8*8:1] what);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("CHECK FAILED %0s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   task bus(input w, input [7:0] a, input [31:0] d);
      begin
         @(posedge clk_i);
         wr_i <= w;
         rd_i <= ~w;
         addr_i <= a;
         wr_data_i <= d;
      end
   endtask
   task stop;
      begin
         @(posedge clk_i);
         wr_i <= 1'b0;
         rd_i <= 1'b0;
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      begin
         bus(1'b1, a, d);
         stop;
      end
   endtask
   task rd(input [7:0] a, input [31:0] exp);
      begin
         bus(1'b0, a, 32'h0);
         stop;
         @(negedge clk_i);
         cmp(exp, rd_data_o, "register");
      end
   endtask
   // Read follows the write with no gap, so a deferred load would show
   task imm_wr(input [7:0] a, input [31:0] d, input [7:0] ra);
      begin
         bus(1'b1, a, d);
         bus(1'b0, ra, 32'h0);
         stop;
         @(negedge clk_i);
         cmp(d, rd_data_o, "shadow");
      end
   endtask
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      for (i = 0; i < 10; i = i + 1)
         rd({i[5:0], 2'b00}, (i == 3) ? 32'h00010000 : 32'h0);
      cmp(32'h0, {20'h0, pwm_o, pwm_oe_o}, "idle");
      $display("test reset done");
      wr(`PBWO_ADDR_OUT_EN, 32'h3f);
      wr(`PBWO_ADDR_NEG_POL, 32'h2a);
      wr(`PBWO_ADDR_OVR_EN, 32'hffffff0f);
      wr(`PBWO_ADDR_OVR_LVL, 32'h05);
      repeat (4) @(negedge clk_i);
      cmp({26'h0, ((6'h05 ^ 6'h2a) & 6'h0f) | (6'h2a & 6'h30)}, {26'h0, pin}, "pins");
      rd(`PBWO_ADDR_OVR_EN, 32'h0f);
      rd(`PBWO_ADDR_NEG_POL, 32'h2a);
      wr(`PBWO_ADDR_OUT_EN, 32'h0c);
      repeat (3) @(negedge clk_i);
      cmp(32'h0c, {26'h0, pwm_oe_o}, "enable");
      wr(`PBWO_ADDR_OVR_EN, 32'h0);
      wr(`PBWO_ADDR_NEG_POL, 32'h0);
      wr(`PBWO_ADDR_OUT_EN, 32'h3f);
      $display("test output done");
      wr(`PBWO_ADDR_CHAN_CTL, 32'h003f0000);
      imm_wr(`PBWO_ADDR_PERIOD, 32'h10, `PBWO_ADDR_PSHADOW);
      for (i = 0; i < 6; i = i + 1)
         imm_wr(8'h40 + {i[5:0], 2'b00}, {16'h0, CMPV[16*i +: 16]}, 8'h60 + {i[5:0], 2'b00});
      wr(`PBWO_ADDR_CHAN_CTL, 32'h0);
      // Zero: ch3 low, ch4 toggle, rest high; period: ch3 high
      wr(`PBWO_ADDR_WAVE_A, 32'h00800b6a);
      // Compare up: ch0..2 low, ch4 toggle
      wr(`PBWO_ADDR_WAVE_B, 32'h00000315);
      cnt_tick_i <= 1'b1;
      wr(`PBWO_ADDR_CNT_CTL, 32'h100);
      wr(`PBWO_ADDR_PERIOD, 32'h20);
      rd(`PBWO_ADDR_PSHADOW, 32'h10);
      repeat (20) @(posedge clk_i);
      rd(`PBWO_ADDR_PSHADOW, 32'h20);
      repeat (40) @(posedge clk_i);
      for (k = 0; k < 6; k = k + 1)
         hi[k] = 0;
      repeat (33) begin
         @(negedge clk_i);
         for (k = 0; k < 6; k = k + 1)
            hi[k] = hi[k] + pin[k];
      end
      for (k = 0; k < 6; k = k + 1)
         cmp({24'h0, DUTY[8*k +: 8]}, hi[k], "duty");
      $display("test wave done");
      close_out;
   end
endmodule // test_pwm_buffer_wave_output
